// >>> bench/ext_mem_model.sv
// Purpose: behavioural external memory answering the bus cycle sequencer
// Assumes: 256 bytes addressed by the low address byte
// Notes:   i_stall counts clocks from strobe assertion before ready or acknowledge
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
    input  wire logic        i_clk,
    input  wire logic [23:0] i_addr,
    input  wire logic [7:0]  i_data,
    input  wire logic        i_read_n,
    input  wire logic        i_write_n,
    input  wire logic        i_read_not_write,
    input  wire logic        i_data_strobe_n,
    input  wire logic [7:0]  i_stall,
    output logic             o_ready_n,
    output logic             o_ack_n,
    output logic [7:0]       o_data
);
    logic [7:0] mem [256];
    logic [7:0] cnt_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    wire        rd = !i_read_n || (!i_data_strobe_n && i_read_not_write);
    wire        wr = !i_write_n || (!i_data_strobe_n && !i_read_not_write);
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'hFF;
        end
    end
    always @(posedge i_clk) begin
        cnt_q <= (rd || wr) ? cnt_q + 8'h01 : 8'h00;
        if (wr) mem[i_addr[7:0]] <= i_data;
        if (rd) last_q <= mem[i_addr[7:0]];
    end
    // slow answers hold ready low long enough to be seen before T3
    assign o_ready_n = !((rd || wr) && cnt_q < i_stall);
    // acknowledge follows the data strobe, released as soon as it rises
    assign o_ack_n = !(!i_data_strobe_n && cnt_q >= i_stall);
    // a released bus shows the inverse of its last value, not a stale copy
    assign o_data = rd ? mem[i_addr[7:0]] : ~last_q;
endmodule
`default_nettype wire

// >>> bench/test_ext_bus_cycle_sequencer.sv
// Purpose: self-checking bench for the external bus cycle sequencer
// Assumes: memory model on the far side, one 20 MHz clock
// Notes:   latencies counted in clocks from the taking edge to o_done
`timescale 1ns/100ps
`default_nettype none
module test_ext_bus_cycle_sequencer;
    import ext_bus_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [1:0]  fmt = 2'h0;
    logic        mux = 1'b0;
    logic [3:0]  cps = 4'h2;
    logic        req = 1'b0;
    logic        wr = 1'b0;
    logic        io = 1'b0;
    logic [23:0] adr = 24'h000000;
    logic [7:0]  wd = 8'h00;
    logic [7:0]  stall = 8'h00;
    logic        ready_n, ack_n, oe, cs_n, ale, rd_n, wr_n, memory_request_n_n, io_request_n_n, rnw, as_n, ds_n;
    logic        done, busy;
    logic [7:0]  din, dout, rdata;
    logic [23:0] aout;
    int          fail_count = 0;
    int          comparisons = 0;
    int          lat, csc, stc, alec, asc, bad;
    always #25 clk = ~clk;
    ext_bus_cycle_sequencer ext_bus_cycle_sequencer_inst (.i_clk(clk), .i_rst_n(rst_n),
        .i_format(fmt), .i_muxed(mux), .i_clk_per_state(cps), .i_req(req), .i_write(wr),
        .i_io(io), .i_addr(adr), .i_wdata(wd), .i_ready_n(ready_n),
        .i_transfer_acknowledge_n(ack_n), .i_data(din), .o_addr(aout), .o_data(dout),
        .o_data_oe(oe), .o_chip_select_n(cs_n), .o_address_latch(ale), .o_read_n(rd_n),
        .o_write_n(wr_n), .o_memory_request_n(memory_request_n_n), .o_io_request_n(io_request_n_n),
        .o_read_not_write(rnw), .o_address_strobe_n(as_n), .o_data_strobe_n(ds_n),
        .o_rdata(rdata), .o_done(done), .o_busy(busy));
    ext_mem_model ext_mem_model_inst (.i_clk(clk), .i_addr(aout), .i_data(dout),
        .i_read_n(rd_n), .i_write_n(wr_n), .i_read_not_write(rnw), .i_data_strobe_n(ds_n),
        .i_stall(stall), .o_ready_n(ready_n), .o_ack_n(ack_n), .o_data(din));
    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            $display("wrong value at %0t: %s", $time, msg);
            fail_count++;
        end
    endtask
    // one request held until o_done; the bus is watched at every falling edge
    task automatic run(input logic [1:0] f, input logic m, input logic [3:0] n,
                       input logic w, input logic q, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {fmt, mux, cps, wr, io, adr, wd, req} = {f, m, n, w, q, 16'hA500, a, d, 1'b1};
        {lat, csc, stc, alec, asc, bad} = '0;
        do begin
            @(negedge clk);
            lat++;
            if (!cs_n) begin csc++; if (aout !== adr) bad++; end
            if (ale) begin alec++; if (m && (dout !== a || oe !== 1'b1)) bad++; end
            if (!rd_n || !wr_n) begin stc++; if ({memory_request_n_n, io_request_n_n} !== {q, !q}) bad++; end
            if (!rd_n && m && oe) bad++;
            if (!wr_n && (dout !== d || oe !== 1'b1)) bad++;
            if (!as_n) begin asc++; if ((ds_n && !w) || aout !== adr || rnw !== !w) bad++; end
            if (!ds_n && w && (dout !== d || oe !== 1'b1)) bad++;
        end while (done !== 1'b1 && lat < 600);
        req = 1'b0;
        check({cs_n, rd_n, wr_n, memory_request_n_n, io_request_n_n, as_n, ds_n, ale, oe}, 9'h1FC, "idle");
        check(bad, 0, "bus signals in cycle");
    endtask
    task automatic test_reset;
        check({cs_n, rd_n, wr_n, memory_request_n_n, io_request_n_n, as_n, ds_n, rnw, ale, oe}, 10'h3FC, "rst");
        check({done, busy}, 2'h0, "done busy in reset");
        $display("test reset finished");
    endtask
    task automatic test_latch_sep;
        for (int q = 0; q < 2; q++) begin
            run(FMT_LATCH, 1'b0, 4'h2, 1'b1, q[0], 8'h10 + q[7:0], 8'hC3 ^ q[7:0]);
            check(lat, 9, "write latency");
            check(csc, 8, "cs span");
            check(stc, 4, "write strobe span");
            check(alec > 0 && alec < 2, 1, "latch pulse");
            run(FMT_LATCH, 1'b0, 4'h2, 1'b0, q[0], 8'h10 + q[7:0], 8'h00);
            check(lat, 9, "read latency");
            check(stc, 4, "read strobe span");
            check(rdata, 8'hC3 ^ q[7:0], "read data");
        end
        $display("test latch separate finished");
    endtask
    task automatic test_latch_mux;
        run(FMT_LATCH, 1'b1, 4'hF, 1'b1, 1'b0, 8'h3C, 8'h96);
        check(lat, 61, "mux write at 15 clocks");
        check(alec > 0 && alec < 15, 1, "latch pulse 15");
        run(FMT_LATCH, 1'b1, 4'h1, 1'b0, 1'b1, 8'h3C, 8'h00);
        check(lat, 9, "below minimum acts as 2");
        check(rdata, 8'h96, "mux read data");
        $display("test latch mux finished");
    endtask
    task automatic test_wait;
        for (int w = 0; w < 2; w++) begin
            stall = 8'h0C;
            run(FMT_LATCH, w[0], 4'h3, w[0], 1'b0, 8'h55, 8'h5A);
            stall = 8'h00;
            check(lat > 13 && (lat - 13) % 3 == 0, 1, "whole wait states");
            check(stc, lat - 7, "strobe held through waits");
            check(csc, lat - 1, "chip select span");
        end
        check(rdata, 8'hFF, "rdata stands");
        $display("test wait finished");
    endtask
    task automatic test_strobe;
        run(FMT_STROBE, 1'b0, 4'h2, 1'b1, 1'b0, 8'h77, 8'h69);
        check(lat, 17, "strobe write eight states");
        check(asc, 10, "write strobes S2 to S7");
        check(bad, 0, "strobe write bus signals");
        run(FMT_STROBE, 1'b0, 4'h2, 1'b0, 1'b0, 8'h77, 8'h00);
        check(lat, 17, "eight states");
        check(asc, 10, "strobes S2 to S7");
        check(rdata, 8'h69, "strobe read data");
        stall = 8'h0C;
        run(FMT_STROBE, 1'b0, 4'h2, 1'b0, 1'b0, 8'h55, 8'h00);
        stall = 8'h00;
        check(lat > 17 && (lat - 17) % 2 == 0, 1, "acknowledge waits");
        check(asc, lat - 7, "strobes through waits");
        check(rdata, 8'h5A, "slow read data");
        $display("test strobe finished");
    endtask
    task automatic test_native;
        run(FMT_NATIVE, 1'b0, 4'h2, 1'b0, 1'b0, 8'h3C, 8'h00);
        check(lat, 1, "native answers at once");
        check(csc, 0, "native no cycle");
        $display("test native finished");
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        test_reset();
        rst_n = 1'b1;
        test_latch_sep();
        test_latch_mux();
        test_wait();
        test_strobe();
        test_native();
        complete_run();
    end
    // the tests take under a thousand clocks; ten thousand means a hang
    initial begin
        #500000;
        fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire

// >>> core/ext_bus_cycle_sequencer.sv
// Purpose: bus cycle sequencer for one chip select, latch and strobe formats
// Assumes: request is held until o_done; config stable during a cycle
// Notes:   native format just passes no cycle; a request there is answered at once
`timescale 1ns/100ps
`default_nettype none
module ext_bus_cycle_sequencer (
    input  wire logic                           i_clk,
    input  wire logic                           i_rst_n,
    input  wire logic [1:0]                     i_format,
    input  wire logic                           i_muxed,
    input  wire logic [ext_bus_pkg::CNT_W-1:0]  i_clk_per_state,
    input  wire logic                           i_req,
    input  wire logic                           i_write,
    input  wire logic                           i_io,
    input  wire logic [ext_bus_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [ext_bus_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                           i_ready_n,
    input  wire logic                           i_transfer_acknowledge_n,
    input  wire logic [ext_bus_pkg::DATA_W-1:0] i_data,
    output logic [ext_bus_pkg::ADDR_W-1:0]      o_addr,
    output logic [ext_bus_pkg::DATA_W-1:0]      o_data,
    output logic                                o_data_oe,
    output logic                                o_chip_select_n,
    output logic                                o_address_latch,
    output logic                                o_read_n,
    output logic                                o_write_n,
    output logic                                o_memory_request_n,
    output logic                                o_io_request_n,
    output logic                                o_read_not_write,
    output logic                                o_address_strobe_n,
    output logic                                o_data_strobe_n,
    output logic [ext_bus_pkg::DATA_W-1:0]      o_rdata,
    output logic                                o_done,
    output logic                                o_busy
);
    import ext_bus_pkg::*;

    seq_state_e state_q;
    seq_state_e state_d;
    logic       st_last;
    logic       st_mid;
    logic       start;
    logic       ready_low_q;
    logic       ack_seen_q;
    logic       wr_q;
    logic       io_q;
    logic       mux_q;
    logic       fmt_strobe_q;
    logic       native_req;

    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] data_q;
    logic              data_oe_q;
    logic              cs_n_q;
    logic              ale_q;
    logic              rd_n_q;
    logic              wr_n_q;
    logic              memory_request_n_n_q;
    logic              io_request_n_n_q;
    logic              rnw_q;
    logic              as_n_q;
    logic              ds_n_q;
    logic [DATA_W-1:0] rdata_q;
    logic              done_q;

    // edge of each state, named from the state being entered or, for the end ones, the state being left
    wire idle      = (state_q == ST_IDLE);
    wire enter_t1  = start && (i_format == FMT_LATCH);
    wire enter_s0  = start && (i_format == FMT_STROBE);
    wire enter_t2  = (state_q == ST_T1) && st_last;
    wire t3_end    = ((state_q == ST_T3) || (state_q == ST_TW)) && st_last;
    // ready low sampled one clock before the T3 boundary stretches the cycle
    wire go_wait   = t3_end && ready_low_q;
    wire enter_t4  = t3_end && !ready_low_q;
    wire end_t4    = (state_q == ST_T4) && st_last;
    wire enter_s1  = (state_q == ST_S0) && st_last;
    wire enter_s2  = (state_q == ST_S1) && st_last;
    wire s4_end    = (state_q == ST_S4) && st_last;
    wire enter_s7  = (state_q == ST_S6) && st_last;
    wire end_s7    = (state_q == ST_S7) && st_last;
    wire mux_rd_t2 = enter_t2 && mux_q && !wr_q;

    assign start      = idle && i_req && !done_q;
    assign native_req = start && (i_format == FMT_NATIVE);

    state_timer state_timer_inst (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_restart (start),
        .i_len     (i_clk_per_state),
        .o_last    (st_last),
        .o_mid     (st_mid)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (enter_t1) begin
                    state_d = ST_T1;
                end else if (enter_s0) begin
                    state_d = ST_S0;
                end
            end
            ST_T1:   if (st_last) state_d = ST_T2;
            ST_T2:   if (st_last) state_d = ST_T3;
            ST_T3:   if (st_last) state_d = go_wait ? ST_TW : ST_T4;
            ST_TW:   if (st_last) state_d = go_wait ? ST_TW : ST_T4;
            ST_T4:   if (st_last) state_d = ST_IDLE;
            ST_S0:   if (st_last) state_d = ST_S1;
            ST_S1:   if (st_last) state_d = ST_S2;
            ST_S2:   if (st_last) state_d = ST_S3;
            ST_S3:   if (st_last) state_d = ST_S4;
            // each extra wait is a whole state long
            ST_S4:   if (st_last && ack_seen_q) state_d = ST_S5;
            ST_S5:   if (st_last) state_d = ST_S6;
            ST_S6:   if (st_last) state_d = ST_S7;
            ST_S7:   if (st_last) state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // registered samples: a level seen one clock before the boundary counts
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ready_low_q <= 1'b0;
            ack_seen_q  <= 1'b0;
        end else begin
            ready_low_q <= !i_ready_n;
            ack_seen_q  <= !i_transfer_acknowledge_n;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q         <= 1'b0;
            io_q         <= 1'b0;
            mux_q        <= 1'b0;
            fmt_strobe_q <= 1'b0;
        end else if (start) begin
            wr_q         <= i_write;
            io_q         <= i_io;
            mux_q        <= i_muxed;
            fmt_strobe_q <= (i_format == FMT_STROBE);
        end
    end

    // address and chip select
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_q <= 24'h000000;
            cs_n_q <= 1'b1;
        end else if (enter_t1) begin
            addr_q <= i_addr;
            cs_n_q <= 1'b0;
        end else if (enter_s1) begin
            addr_q <= i_addr;
            cs_n_q <= 1'b0;
        end else if (end_t4 || end_s7) begin
            cs_n_q <= 1'b1;
        end
    end

    // data bus drive
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            data_q    <= 8'h00;
            data_oe_q <= 1'b0;
        end else if (enter_t1) begin
            data_q    <= i_muxed ? i_addr[7:0] : i_wdata;
            data_oe_q <= i_muxed || i_write;
        end else if (enter_t2 && mux_q) begin
            data_q    <= i_wdata;
            data_oe_q <= wr_q;
        end else if (enter_s0 && i_write) begin
            data_q    <= i_wdata;
        end else if ((state_q == ST_S2) && st_last && wr_q) begin
            data_oe_q <= 1'b1;
        end else if (end_t4 || end_s7) begin
            data_oe_q <= 1'b0;
        end
    end

    // address latch pulse: high for the first half of T1
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ale_q <= 1'b0;
        end else if (enter_t1) begin
            ale_q <= 1'b1;
        end else if ((state_q == ST_T1) && st_mid) begin
            ale_q <= 1'b0;
        end
    end

    // read and write strobes with request qualifiers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_n_q   <= 1'b1;
            wr_n_q   <= 1'b1;
            memory_request_n_n_q <= 1'b1;
            io_request_n_n_q <= 1'b1;
        end else if (enter_t2) begin
            rd_n_q   <= wr_q;
            wr_n_q   <= !wr_q;
            memory_request_n_n_q <= io_q;
            io_request_n_n_q <= !io_q;
        end else if (enter_t4) begin
            rd_n_q   <= 1'b1;
            wr_n_q   <= 1'b1;
        end else if (end_t4) begin
            memory_request_n_n_q <= 1'b1;
            io_request_n_n_q <= 1'b1;
        end
    end

    // strobe-and-acknowledge signals
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rnw_q  <= 1'b1;
            as_n_q <= 1'b1;
            ds_n_q <= 1'b1;
        end else if (enter_s0) begin
            rnw_q  <= 1'b1;
        end else if (enter_s2) begin
            as_n_q <= 1'b0;
            ds_n_q <= wr_q;
            rnw_q  <= !wr_q;
        end else if (s4_end && ack_seen_q && wr_q) begin
            ds_n_q <= 1'b0;
        end else if ((state_q == ST_S3) && st_last && wr_q) begin
            ds_n_q <= 1'b0;
        end else if (enter_s7) begin
            as_n_q <= 1'b1;
            ds_n_q <= 1'b1;
        end else if (end_s7) begin
            rnw_q  <= 1'b1;
        end
    end

    // read data capture and completion
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= 8'h00;
            done_q  <= 1'b0;
        end else begin
            if ((enter_t4 || enter_s7) && !wr_q) begin
                rdata_q <= i_data;
            end
            done_q <= end_t4 || end_s7 || native_req;
        end
    end

    assign o_addr             = addr_q;
    assign o_data             = data_q;
    assign o_data_oe          = data_oe_q;
    assign o_chip_select_n    = cs_n_q;
    assign o_address_latch    = ale_q;
    assign o_read_n           = rd_n_q;
    assign o_write_n          = wr_n_q;
    assign o_memory_request_n = memory_request_n_n_q;
    assign o_io_request_n     = io_request_n_n_q;
    assign o_read_not_write   = rnw_q;
    assign o_address_strobe_n = as_n_q;
    assign o_data_strobe_n    = ds_n_q;
    assign o_rdata            = rdata_q;
    assign o_done             = done_q;
    assign o_busy             = !idle;

    a_t3_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_T3) && ($past(state_q) == ST_T3) |-> $stable(o_read_n) && $stable(o_write_n)
        && $stable(o_data_oe) && $stable(o_address_latch))
        else $error("bus outputs changed during T3");
    a_t1_to_t2: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(state_q == ST_T1) |-> ##[2:15] (state_q == ST_T2))
        else $error("T1 did not move to T2 in time");
    a_ale_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(state_q == ST_T1) |-> o_address_latch ##[1:7] !o_address_latch)
        else $error("latch pulse not raised then dropped in T1");
    a_strobe_t2: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(state_q == ST_T2) |-> (o_read_n != o_write_n) && (o_memory_request_n != o_io_request_n))
        else $error("strobe or qualifier wrong in T2");
    a_t4_negate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_T4) |-> o_read_n && o_write_n)
        else $error("strobe still asserted in T4");
    a_wait_ready: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        t3_end && ready_low_q |=> (state_q == ST_TW))
        else $error("ready low did not add a wait state");
    a_s2_strobes: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(state_q == ST_S2) && !wr_q |-> !o_address_strobe_n && !o_data_strobe_n)
        else $error("strobes not asserted entering S2");
    a_s7_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(state_q == ST_S7) |-> o_address_strobe_n && o_data_strobe_n)
        else $error("strobes not negated entering S7");
    a_idle_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        idle && $past(idle) |-> o_read_n && o_write_n && !o_data_oe && !o_address_latch)
        else $error("bus not quiet between cycles");
    a_s0_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(state_q == ST_S0) |-> o_read_not_write)
        else $error("read/not-write low in S0");

    // the first clock of a state may move pins, so the holds start on its second clock
    a_s3_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_S3) && ($past(state_q) == ST_S3) |-> $stable(o_addr)
        && $stable(o_address_strobe_n) && $stable(o_data_strobe_n) && $stable(o_read_not_write))
        else $error("bus signals changed during S3");
    a_t4_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_T4) && ($past(state_q) == ST_T4) |-> $stable(o_addr) && $stable(o_data)
        && $stable(o_data_oe) && !o_chip_select_n)
        else $error("address or data moved before T4 ended");
    a_t1_drive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        enter_t1 |=> !o_chip_select_n && (o_addr == $past(i_addr))
        && (o_data_oe == ($past(i_muxed) || $past(i_write))) && (!mux_q || o_data == o_addr[7:0]))
        else $error("T1 address, chip select or data drive wrong");
    a_mux_addr_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        mux_rd_t2 |=> !o_data_oe && !o_read_n)
        else $error("multiplexed read kept the address on the data bus in T2");
    a_mux_wr_data: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        enter_t2 && mux_q && wr_q |=> o_data_oe && !o_write_n && (o_data == $past(i_wdata)))
        else $error("multiplexed write data not driven in T2");
    a_qual_t2: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(state_q == ST_T2) |-> (o_write_n == !wr_q) && (o_io_request_n == !io_q))
        else $error("strobe or qualifier does not match the request");
    a_read_capture: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (enter_t4 || enter_s7) && !wr_q |=> (o_rdata == $past(i_data)))
        else $error("read data not captured at the state edge");
    a_s1_addr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        enter_s1 |=> !o_chip_select_n && (o_addr == $past(i_addr)))
        else $error("address not valid entering S1");
    // the acknowledge is judged one clock early, so a late one costs a whole state
    a_s4_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s4_end && !ack_seen_q |=> (state_q == ST_S4))
        else $error("S4 left without acknowledge");
    a_done_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_done |=> !o_done)
        else $error("done stood for more than one clock");

    c_latch_read:  cover property (@(posedge i_clk) end_t4 && !wr_q && !mux_q);
    c_mux_write:   cover property (@(posedge i_clk) end_t4 && wr_q && mux_q);
    c_wait_state:  cover property (@(posedge i_clk) state_q == ST_TW);
    c_strobe_read: cover property (@(posedge i_clk) end_s7 && fmt_strobe_q && !wr_q);
    c_strobe_write: cover property (@(posedge i_clk) end_s7 && fmt_strobe_q && wr_q);
endmodule
`default_nettype wire

// >>> core/ext_bus_pkg.sv
// Purpose: constants for the external bus cycle sequencer
// Assumes: one 20 MHz system clock, one chip select per sequencer
// Notes:   rules carried by the sequencer follow
// Function
// - address-latch cycles run four ordered states T1..T4 plus waits
// - each state lasts 2 to 15 clocks, set per chip select
// - latch pulse high at start of T1, low at middle of T1
// - separate-bus write drives address, chip select, data in T1
// - separate bus: strobe and memory or io qualifier asserted in T2
// - multiplexed read drives address onto data bus in T1, chip select
// - multiplexed read removes address in T2, asserts read strobe and qualifier
// - multiplexed write: address in T1, write data plus write strobe in T2
// - T3 holds outputs; ready low before T3 adds wait states until high
// - reads capture data at start of T4, negate read strobe, end
// - separate write negates write strobe at T4, holds buses to T4 end
// - multiplexed write negates write strobe at start of T4
// - strobe-and-acknowledge format runs eight states S0..S7
// - strobe format read starts in S0 with read/not-write high
// - entering S1 the 24-bit address is valid
// - rising edge beginning S2 asserts address strobe, and data strobe for reads; writes assert data strobe entering S4
// - S3 leaves every bus signal unchanged; writes turn on the data bus drive entering S3
// - multiplexed T1 puts low address byte on data and address bus
// - format and clocks per state per chip select; native is default
// - S4 waits for acknowledge, inserting whole-state waits until seen
// - entering S7 read latches data and negates both strobes
package ext_bus_pkg;
    localparam int          ADDR_W        = 24;
    localparam int          DATA_W        = 8;
    localparam int          CNT_W         = 4;
    localparam logic [3:0]  CLK_PER_MIN   = 4'h2;
    localparam logic [3:0]  CLK_PER_MAX   = 4'hF;
    localparam logic [3:0]  CLK_PER_RESET = 4'hF;
    localparam logic [1:0]  FMT_NATIVE    = 2'h0;
    localparam logic [1:0]  FMT_LATCH     = 2'h1;
    localparam logic [1:0]  FMT_STROBE    = 2'h2;
    localparam logic [1:0]  FMT_RESET     = 2'h0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_T1   = 4'h1,
        ST_T2   = 4'h2,
        ST_T3   = 4'h3,
        ST_TW   = 4'h4,
        ST_T4   = 4'h5,
        ST_S0   = 4'h6,
        ST_S1   = 4'h7,
        ST_S2   = 4'h8,
        ST_S3   = 4'h9,
        ST_S4   = 4'hA,
        ST_S5   = 4'hB,
        ST_S6   = 4'hC,
        ST_S7   = 4'hD
    } seq_state_e;
endpackage

// >>> core/state_timer.sv
// Purpose: per-state clock counter giving a last-clock and mid-state pulse
// Assumes: length is held constant while a cycle runs
// Notes:   length below the minimum is raised to it
`timescale 1ns/100ps
`default_nettype none
module state_timer (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_restart,
    input  wire logic [ext_bus_pkg::CNT_W-1:0] i_len,
    output logic                         o_last,
    output logic                         o_mid
);
    import ext_bus_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] len_eff;
    logic [CNT_W-1:0] half;

    // a one-clock state would leave no room for the mid-state latch edge
    assign len_eff = (i_len < CLK_PER_MIN) ? CLK_PER_MIN : i_len;
    assign half    = len_eff >> 1;
    assign o_last  = (cnt_q == len_eff - 4'h1);
    assign o_mid   = (cnt_q == half - 4'h1);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 4'h0;
        end else if (i_restart || o_last) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    a_last_bounded: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        cnt_q <= CLK_PER_MAX - 4'h1)
        else $error("state counter ran past its longest length");
endmodule
`default_nettype wire
